//--- design/phy_mgmt_pkg.sv
// Register map, field positions and reset values of the management bank
`default_nettype none
package phy_mgmt_pkg;
  // Register indices on the management port
  localparam logic [4:0] PARTNER_ABILITY_IDX = 5'h05;
  localparam logic [4:0] AN_EXPANSION_IDX    = 5'h06;
  localparam logic [4:0] STATUS_CONTROL_IDX  = 5'h10;
  localparam logic [4:0] SPECIAL_CONTROL_IDX = 5'h11;

  // Expansion register fields
  localparam int EXP_PAR_FAULT_BIT    = 4;
  localparam int EXP_PARTNER_NP_BIT   = 3;
  localparam int EXP_LOCAL_NP_BIT     = 2;
  localparam int EXP_PAGE_RX_BIT      = 1;
  localparam int EXP_PARTNER_AN_BIT   = 0;

  // Status and control register fields
  localparam int SC_RSVD_HI_MSB       = 15;
  localparam int SC_RSVD_HI_LSB       = 14;
  localparam int SC_RPD_DISABLE_BIT   = 13;
  localparam int SC_RSVD_12_BIT       = 12;
  localparam int SC_SYNC_BIT          = 11;
  localparam int SC_PD100_BIT         = 10;
  localparam int SC_PD10_BIT          = 9;
  localparam int SC_POLARITY_BIT      = 8;
  localparam int SC_ADDR_MSB          = 6;
  localparam int SC_ADDR_LSB          = 2;
  localparam int SC_SPEED_BIT         = 1;
  localparam int SC_DUPLEX_BIT        = 0;
  // Writable bits of the status and control register
  localparam logic [15:0] SC_WRITE_MASK  = 16'hF000;
  localparam logic [15:0] SC_CTRL_RESET  = 16'h2000;

  // Special control register fields
  localparam int SP_SCR_BYPASS_BIT    = 15;
  localparam int SP_ENC_BYPASS_BIT    = 14;
  localparam int SP_FORCE_H_BIT       = 13;
  localparam int SP_FORCE_34_BIT      = 12;
  localparam int SP_VALID_LINK_BIT    = 11;
  localparam int SP_SYMERR_EN_BIT     = 10;
  localparam int SP_CRS_DISABLE_BIT   = 9;
  localparam int SP_DPD_DISABLE_BIT   = 8;
  localparam int SP_AN_LOOPBACK_BIT   = 7;
  localparam int SP_MDI_TRISTATE_BIT  = 6;
  localparam int SP_FORCE_POL_BIT     = 5;
  localparam int SP_AUTOPOL_DIS_BIT   = 4;
  localparam int SP_SQUELCH_DIS_BIT   = 3;
  localparam int SP_EXT_SQUELCH_BIT   = 2;
  localparam int SP_LINK_INT_DIS_BIT  = 1;
  localparam int SP_JABBER_DIS_BIT    = 0;
  localparam logic [15:0] SP_RESET    = 16'h0000;

  // Unit power-down indications and strap address after reset
  localparam logic        PD_RESET    = 1'b1;
  localparam logic [4:0]  ADDR_RESET  = 5'h00;
endpackage : phy_mgmt_pkg
`default_nettype wire

//--- design/phy_mgmt_regs.sv
// Management register bank: partner ability, expansion, status/control, special control
//
// Operation
// - Partner ability shows received technology field and selector field, read-only.
// - Partner ability shows partner next page, acknowledge and remote fault, read-only.
// - Parallel detection fault latches high, clears on read, resets to zero.
// - Page received latches high on new page, clears on read, resets zero.
// - Expansion reports partner NP, local NP, partner AN ability; read-only.
// - Automatic reduced power down unless disable bit set; disable resets to one.
// - Status shows 100 Mbps deserializer sync, read-only.
// - Separate 100 and 10 unit power-down indications, one means down, reset one.
// - Detected 10 Mbps receive polarity reported read-only, one is reversed.
// - Sampled PHY address shown as read-only five-bit field.
// - Negotiated speed and duplex reported read-only.
// - Scrambler and 4B/5B bypass controls, reset zero, honoured while set.
// - Force H pattern and 34 pattern controls, reset to normal.
// - Valid link control forces 100 Mbps link valid; reset normal.
// - Symbol error output driven only while its enable is set; reset zero.
// - Carrier sense disable suppresses 100 Mbps receive carrier sense; reset clear.
// - Dynamic power-down performed unless its disable is set; reset zero.
// - Auto-negotiation loopback control; reset to normal mode.
// - Medium interface tri-state control turns transmit driver off; reset normal.
// - Auto polarity correction unless disabled; force polarity selects reversed.
// - Squelch test disable and extended squelch control, both reset zero.
// - Link integrity disable and jabber disable controls, reset normal.
`default_nettype none
module phy_mgmt_regs (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,

  // Management register port
  input  wire logic [4:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,

  // Address strap pins
  input  wire logic [4:0]  phyAddrPins,

  // Partner page and latched events
  input  wire logic [15:0] partnerPage,
  input  wire logic        pageRxPulse,
  input  wire logic        parFaultPulse,

  // Abilities and negotiated result
  input  wire logic        partnerNpAble,
  input  wire logic        localNpAble,
  input  wire logic        partnerAnAble,
  input  wire logic        anSpeed100,
  input  wire logic        anFullDuplex,

  // Line status
  input  wire logic        rxDeserSync,
  input  wire logic        rxPolDetected,
  input  wire logic        energyDetect,
  input  wire logic        linkUp,

  // Raw receive indications
  input  wire logic        symErrIn,
  input  wire logic        rxCrs100In,

  // Transmit controls
  output logic             scramblerBypass,
  output logic             encoderBypass,
  output logic             forceHPattern,
  output logic             force34Pattern,
  output logic             mdiDriverEnable,

  // Receive controls
  output logic             forceLinkValid,
  output logic             symErrOut,
  output logic             rxCrs100Out,
  output logic             anLoopback,
  output logic             rxPolInvert,

  // Line controls
  output logic             squelchTestEnable,
  output logic             extSquelchEnable,
  output logic             linkIntegrityEnable,
  output logic             jabberEnable,

  // Power controls
  output logic             power100Down,
  output logic             power10Down
);

  // Register state
  logic [15:0] scCtrl_q;
  logic [15:0] scCtrl_d;
  logic [15:0] spCtrl_q;
  logic [15:0] spCtrl_d;
  logic        parFault_q;
  logic        parFault_d;
  logic        pageRx_q;
  logic        pageRx_d;
  logic [15:0] rdData_q;
  logic [15:0] rdData_d;

  // Decoded accesses
  logic        scWrSel;
  logic        spWrSel;
  logic        expRdSel;

  // Strap synchroniser and capture
  logic [4:0]  strapMeta_q;
  logic [4:0]  strapSync_q;
  logic [4:0]  phyAddr_q;
  logic [4:0]  phyAddr_d;
  logic        strapDone_q;
  logic        strapDone_d;
  logic        strapArm_q;
  logic        strapArm_d;

  // Power and datapath gating
  logic        pd100_q;
  logic        pd100_d;
  logic        pd10_q;
  logic        pd10_d;
  logic        symErr_q;
  logic        symErr_d;
  logic        crs100_q;
  logic        crs100_d;
  logic        reducedPower;
  logic        dynPowerDown;
  logic        polInvert;

  // Read word assembly
  logic [15:0] expWord;
  logic [15:0] scWord;

  // Access decode; the master never raises both strobes together
  assign scWrSel  = regWr && (regAddr == phy_mgmt_pkg::STATUS_CONTROL_IDX);
  assign spWrSel  = regWr && (regAddr == phy_mgmt_pkg::SPECIAL_CONTROL_IDX);
  assign expRdSel = regRd && (regAddr == phy_mgmt_pkg::AN_EXPANSION_IDX);

  // Control register writes; read-only bits never take the write data
  always_comb begin
    scCtrl_d = scCtrl_q;
    spCtrl_d = spCtrl_q;
    if (scWrSel) begin
      scCtrl_d = regWrData & phy_mgmt_pkg::SC_WRITE_MASK;
    end
    // Every bit of the special word is a plain control
    if (spWrSel) begin
      spCtrl_d = regWrData;
    end
  end

  // Power-on values; reduced power down starts disabled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scCtrl_q <= phy_mgmt_pkg::SC_CTRL_RESET;
      spCtrl_q <= phy_mgmt_pkg::SP_RESET;
    end else begin
      scCtrl_q <= scCtrl_d;
      spCtrl_q <= spCtrl_d;
    end
  end

  // Latched expansion events; a set in the clearing read cycle wins
  always_comb begin
    parFault_d = parFault_q;
    pageRx_d   = pageRx_q;
    // Clear first, so an event in the read cycle overrides it
    if (expRdSel) begin
      parFault_d = 1'b0;
      pageRx_d   = 1'b0;
    end
    // Events set the bits
    if (parFaultPulse) begin
      parFault_d = 1'b1;
    end
    if (pageRxPulse) begin
      pageRx_d = 1'b1;
    end
  end

  // Latched events start clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      parFault_q <= 1'b0;
      pageRx_q   <= 1'b0;
    end else begin
      parFault_q <= parFault_d;
      pageRx_q   <= pageRx_d;
    end
  end

  // Strap pins come from outside: two flops before use
  // No reset, so the pair already holds pin data when reset lifts
  always_ff @(posedge sys_clk) begin
    strapMeta_q <= phyAddrPins;
    strapSync_q <= strapMeta_q;
  end

  // Address captured once, at the second edge after reset lifts
  // Limitation: pins changed later are ignored until the next reset
  always_comb begin
    strapArm_d  = 1'b1;
    phyAddr_d   = phyAddr_q;
    strapDone_d = strapDone_q;
    // Arm keeps the capture clear of the releasing edge
    if (strapArm_q && !strapDone_q) begin
      phyAddr_d   = strapSync_q;
      strapDone_d = 1'b1;
    end
  end

  // Registers only; the capture decision lives above
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strapArm_q  <= 1'b0;
      phyAddr_q   <= phy_mgmt_pkg::ADDR_RESET;
      strapDone_q <= 1'b0;
    end else begin
      strapArm_q  <= strapArm_d;
      phyAddr_q   <= phyAddr_d;
      strapDone_q <= strapDone_d;
    end
  end

  // Power management: no cable energy drops both units unless disabled
  // Energy is taken as given; any debounce belongs upstream
  assign reducedPower = !scCtrl_q[phy_mgmt_pkg::SC_RPD_DISABLE_BIT] && !energyDetect;
  // With a link up, the unit of the unused speed is switched off
  assign dynPowerDown = !spCtrl_q[phy_mgmt_pkg::SP_DPD_DISABLE_BIT] && linkUp;

  always_comb begin
    pd100_d = 1'b0;
    pd10_d  = 1'b0;
    if (reducedPower) begin
      // No energy on the cable: both units sleep
      pd100_d = 1'b1;
      pd10_d  = 1'b1;
    end else if (dynPowerDown) begin
      // Link up: only the unit of the unused speed sleeps
      pd100_d = !anSpeed100;
      pd10_d  = anSpeed100;
    end
  end

  // Both units report down until the first computed value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pd100_q <= phy_mgmt_pkg::PD_RESET;
      pd10_q  <= phy_mgmt_pkg::PD_RESET;
    end else begin
      pd100_q <= pd100_d;
      pd10_q  <= pd10_d;
    end
  end

  // Gated receive outputs, registered to keep data outputs glitch free
  always_comb begin
    symErr_d = 1'b0;
    crs100_d = 1'b0;
    // Symbol errors pass only while enabled
    if (spCtrl_q[phy_mgmt_pkg::SP_SYMERR_EN_BIT]) begin
      symErr_d = symErrIn;
    end
    // Carrier sense is blocked while disabled
    if (!spCtrl_q[phy_mgmt_pkg::SP_CRS_DISABLE_BIT]) begin
      crs100_d = rxCrs100In;
    end
  end

  // Gated outputs stay quiet through reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      symErr_q <= 1'b0;
      crs100_q <= 1'b0;
    end else begin
      symErr_q <= symErr_d;
      crs100_q <= crs100_d;
    end
  end

  // Expansion word assembly, reserved bits read zero
  always_comb begin
    expWord = 16'h0000;
    // Latched events
    expWord[phy_mgmt_pkg::EXP_PAR_FAULT_BIT]  = parFault_q;
    expWord[phy_mgmt_pkg::EXP_PAGE_RX_BIT]    = pageRx_q;
    // Live abilities
    expWord[phy_mgmt_pkg::EXP_PARTNER_NP_BIT] = partnerNpAble;
    expWord[phy_mgmt_pkg::EXP_LOCAL_NP_BIT]   = localNpAble;
    expWord[phy_mgmt_pkg::EXP_PARTNER_AN_BIT] = partnerAnAble;
  end

  // Status word: writable high bits plus live status
  always_comb begin
    scWord = scCtrl_q;
    // Live line status
    scWord[phy_mgmt_pkg::SC_SYNC_BIT]     = rxDeserSync;
    // Unit power indications
    scWord[phy_mgmt_pkg::SC_PD100_BIT]    = pd100_q;
    scWord[phy_mgmt_pkg::SC_PD10_BIT]     = pd10_q;
    // Polarity, strap and negotiation result
    scWord[phy_mgmt_pkg::SC_POLARITY_BIT] = rxPolDetected;
    scWord[phy_mgmt_pkg::SC_ADDR_MSB:phy_mgmt_pkg::SC_ADDR_LSB] = phyAddr_q;
    scWord[phy_mgmt_pkg::SC_SPEED_BIT]    = anSpeed100;
    scWord[phy_mgmt_pkg::SC_DUPLEX_BIT]   = anFullDuplex;
  end

  // Read mux; data stands only in the cycle after the strobe
  always_comb begin
    rdData_d = 16'h0000;
    if (regRd) begin
      case (regAddr)
        // Partner word and expansion bits, latched events and live abilities
        phy_mgmt_pkg::PARTNER_ABILITY_IDX: rdData_d = partnerPage;
        phy_mgmt_pkg::AN_EXPANSION_IDX:    rdData_d = expWord;
        // Status word with live fields; special word read back as stored
        phy_mgmt_pkg::STATUS_CONTROL_IDX:  rdData_d = scWord;
        phy_mgmt_pkg::SPECIAL_CONTROL_IDX: rdData_d = spCtrl_q;
        // Unmapped words read as zero
        default:                           rdData_d = 16'h0000;
      endcase
    end
  end

  // Read word register; idle cycles load zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData_q <= 16'h0000;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // Zero outside the answer cycle, so a stale word never lingers
  assign regRdData = rdData_q;

  // Special control bits other than symbol error, carrier sense, dynamic power-down and the two polarity bits drive the datapath directly
  // Transmit path controls
  assign scramblerBypass     = spCtrl_q[phy_mgmt_pkg::SP_SCR_BYPASS_BIT];
  assign encoderBypass       = spCtrl_q[phy_mgmt_pkg::SP_ENC_BYPASS_BIT];
  assign forceHPattern       = spCtrl_q[phy_mgmt_pkg::SP_FORCE_H_BIT];
  assign force34Pattern      = spCtrl_q[phy_mgmt_pkg::SP_FORCE_34_BIT];

  // Receive and negotiation controls
  assign forceLinkValid      = spCtrl_q[phy_mgmt_pkg::SP_VALID_LINK_BIT];
  assign anLoopback          = spCtrl_q[phy_mgmt_pkg::SP_AN_LOOPBACK_BIT];

  // Line driver and 10 Mbps receive controls, active high enables
  assign mdiDriverEnable     = !spCtrl_q[phy_mgmt_pkg::SP_MDI_TRISTATE_BIT];
  assign squelchTestEnable   = !spCtrl_q[phy_mgmt_pkg::SP_SQUELCH_DIS_BIT];
  assign extSquelchEnable    = spCtrl_q[phy_mgmt_pkg::SP_EXT_SQUELCH_BIT];
  assign linkIntegrityEnable = !spCtrl_q[phy_mgmt_pkg::SP_LINK_INT_DIS_BIT];
  assign jabberEnable        = !spCtrl_q[phy_mgmt_pkg::SP_JABBER_DIS_BIT];

  // Forced polarity overrides; auto correction follows the detector
  always_comb begin
    polInvert = 1'b0;
    if (spCtrl_q[phy_mgmt_pkg::SP_FORCE_POL_BIT]) begin
      polInvert = 1'b1;
    end else if (!spCtrl_q[phy_mgmt_pkg::SP_AUTOPOL_DIS_BIT]) begin
      polInvert = rxPolDetected;
    end
  end

  assign rxPolInvert = polInvert;

  // Registered status outputs
  assign symErrOut    = symErr_q;
  assign rxCrs100Out  = crs100_q;
  assign power100Down = pd100_q;
  assign power10Down  = pd10_q;

endmodule : phy_mgmt_regs
`default_nettype wire

//--- verification/mgmt_master.sv
// Station management master model for the register port
`default_nettype none
module mgmt_master (
  // Clock
  input  wire logic        sys_clk,
  // Register port
  output var  logic [4:0]  regAddr,
  output var  logic [15:0] regWrData,
  output var  logic        regWr,
  output var  logic        regRd,
  input  wire logic [15:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus from time zero
  initial begin
    regAddr = 5'h00;
    regWrData = 16'h0000;
    regWr = 1'h0;
    regRd = 1'h0;
  end
  // One-cycle write; data inverted after so stale values never look valid
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge sys_clk);
    regWr <= 1'h0;
    regWrData <= ~d;
  endtask
  // One-cycle read; data taken once the answering edge has settled
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1;
    d = regRdData;
  endtask
endmodule // mgmt_master
`default_nettype wire

//--- verification/phy_mgmt_regs_checker.sv
// Port-level assertions for the management register bank
`default_nettype none
module phy_mgmt_regs_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Register port
  input wire logic [4:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  // Status inputs
  input wire logic [15:0] partnerPage,
  input wire logic        pageRxPulse,
  input wire logic        parFaultPulse,
  input wire logic        rxDeserSync,
  input wire logic        anSpeed100,
  input wire logic        symErrIn,
  input wire logic        rxCrs100In,
  // Derived controls
  input wire logic        scramblerBypass,
  input wire logic        forceHPattern,
  input wire logic        mdiDriverEnable,
  input wire logic        jabberEnable,
  input wire logic        symErrOut,
  input wire logic        rxCrs100Out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Strobes decoded per register
  wire rd05 = regRd && (regAddr == 5'h05);
  wire rd06 = regRd && (regAddr == 5'h06);
  wire rd10 = regRd && (regAddr == 5'h10);
  wire wr11 = regWr && (regAddr == 5'h11);
  property p_lpa; rd05 |=> regRdData == $past(partnerPage); endproperty
  a_lpa: assert property (p_lpa) else $error("partner word wrong");
  property p_fault; parFaultPulse ##1 rd06 |=> regRdData[4]; endproperty
  a_fault: assert property (p_fault) else $error("fault not latched");
  // Second of two quiet reads must see the page bit cleared
  property p_page;
    rd06 && !pageRxPulse ##1 !pageRxPulse ##1 rd06 && !pageRxPulse |=> !regRdData[1];
  endproperty
  a_page: assert property (p_page) else $error("page bit not cleared");
  property p_stat;
    rd10 |=> regRdData[11] == $past(rxDeserSync) && regRdData[1] == $past(anSpeed100);
  endproperty
  a_stat: assert property (p_stat) else $error("status bits wrong");
  property p_ctl;
    wr11 |=> scramblerBypass == $past(regWrData[15]) && forceHPattern == $past(regWrData[13]);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control output wrong");
  property p_tri;
    wr11 |=> mdiDriverEnable != $past(regWrData[6]) && jabberEnable != $past(regWrData[0]);
  endproperty
  a_tri: assert property (p_tri) else $error("enable output wrong");
  property p_sym; symErrOut |-> $past(symErrIn); endproperty
  a_sym: assert property (p_sym) else $error("symbol error leaked");
  property p_crs; rxCrs100Out |-> $past(rxCrs100In); endproperty
  a_crs: assert property (p_crs) else $error("carrier sense leaked");
  // Main scenarios reached
  c_fault: cover property (parFaultPulse ##1 rd06);
  c_wr: cover property (wr11 && regWrData[15]);
  c_sym: cover property (symErrOut);
endmodule // phy_mgmt_regs_checker
`default_nettype wire

//--- verification/tb_phy_mgmt_regs.sv
// Self-checking bench for the management register bank
`default_nettype none
module tb_phy_mgmt_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and register port
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] regAddr, phyAddrPins = 5'h0B;
  logic [15:0] regWrData, regRdData, partnerPage = 16'hA5C3;
  logic regWr, regRd, pageRxPulse = 1'h0, parFaultPulse = 1'h0;
  // Status levels
  logic partnerNpAble = 1'h1, localNpAble = 1'h0, partnerAnAble = 1'h1, anSpeed100 = 1'h1;
  logic anFullDuplex = 1'h0, rxDeserSync = 1'h1, rxPolDetected = 1'h1, energyDetect = 1'h1;
  logic linkUp = 1'h0, symErrIn = 1'h0, rxCrs100In = 1'h0;
  // Design outputs
  logic scramblerBypass, encoderBypass, forceHPattern, force34Pattern, mdiDriverEnable;
  logic forceLinkValid, symErrOut, rxCrs100Out, anLoopback, rxPolInvert, squelchTestEnable;
  logic extSquelchEnable, linkIntegrityEnable, jabberEnable, power100Down, power10Down;
  int err_count = 0;
  int checked = 0;
  phy_mgmt_regs i_dut (.*);
  mgmt_master i_mst (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reads partner, expansion and status words plus a hole; expectations from the current levels
  task automatic t_status(input logic [3:0] ctl);
    logic [15:0] d;
    logic rp, dyn;
    rp = !ctl[1] && !energyDetect;
    dyn = linkUp;
    i_mst.rd(5'h05, d);
    chk(d, partnerPage);
    i_mst.rd(5'h06, d);
    chk(d, {12'h000, partnerNpAble, localNpAble, 1'h0, partnerAnAble});
    i_mst.rd(5'h10, d);
    chk(d, {ctl, rxDeserSync, rp | (dyn & !anSpeed100), rp | (dyn & anSpeed100),
      rxPolDetected, 1'h0, phyAddrPins, anSpeed100, anFullDuplex});
    i_mst.rd(5'h07, d);
    chk(d, 16'h0000);
    $display("status test done");
  endtask
  // Both event pulses for one cycle, released as the next access starts
  task automatic fire();
    @(posedge sys_clk);
    parFaultPulse <= 1'h1;
    pageRxPulse <= 1'h1;
    fork
      begin
        @(posedge sys_clk);
        parFaultPulse <= 1'h0;
        pageRxPulse <= 1'h0;
      end
    join_none
  endtask
  task automatic t_latch();
    logic [15:0] d;
    fire();
    i_mst.rd(5'h06, d);
    chk(d, 16'h001B);
    i_mst.rd(5'h06, d);
    chk(d, 16'h0009);
    fire();
    i_mst.wr(5'h06, 16'h0000);
    i_mst.wr(5'h05, 16'h0000);
    i_mst.rd(5'h06, d);
    chk(d, 16'h001B);
    i_mst.rd(5'h05, d);
    chk(d, partnerPage);
    $display("latch test done");
  endtask
  // Walks a single one through the special control word
  task automatic t_special();
    logic [15:0] d, w;
    @(posedge sys_clk);
    {symErrIn, rxCrs100In, linkUp} <= 3'h7;
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      i_mst.wr(5'h11, w);
      @(posedge sys_clk);
      #1;
      chk({scramblerBypass, encoderBypass, forceHPattern, force34Pattern, forceLinkValid,
        anLoopback, extSquelchEnable, !mdiDriverEnable, !squelchTestEnable,
        !linkIntegrityEnable, !jabberEnable, symErrOut, rxCrs100Out, rxPolInvert,
        power10Down, power100Down}, {w[15:11], w[7], w[2], w[6], w[3], w[1], w[0], w[10],
        !w[9], w[5] | !w[4], !w[8], 1'h0});
      i_mst.rd(5'h11, d);
      chk(d, w);
    end
    i_mst.wr(5'h11, 16'h0000);
    $display("special test done");
  endtask
  // Reduced power, then partner page and status levels except energy, link, symbol error and carrier sense flipped and read-only bits written
  task automatic t_power();
    @(posedge sys_clk);
    energyDetect <= 1'h0;
    i_mst.wr(5'h10, 16'h0000);
    t_status(4'h0);
    chk({14'h0000, power100Down, power10Down}, 16'h0003);
    @(posedge sys_clk);
    partnerPage <= ~partnerPage;
    {partnerNpAble, localNpAble, partnerAnAble, anSpeed100, anFullDuplex, rxDeserSync,
      rxPolDetected} <= ~{partnerNpAble, localNpAble, partnerAnAble, anSpeed100,
      anFullDuplex, rxDeserSync, rxPolDetected};
    i_mst.wr(5'h10, 16'hFFFF);
    t_status(4'hF);
    $display("power test done");
  endtask
  // Watchdog far beyond the roughly 130 cycles the tests need
  initial begin
    #50000;
    err_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    @(posedge sys_clk);
    #1;
    chk({14'h0000, power100Down, power10Down}, 16'h0003);
    @(posedge sys_clk);
    rst <= 1'h0;
    repeat (3) @(posedge sys_clk);
    t_status(4'h2);
    t_latch();
    t_special();
    t_power();
    wrap_up();
  end
endmodule // tb_phy_mgmt_regs
bind phy_mgmt_regs phy_mgmt_regs_checker i_chk (.*);
`default_nettype wire
